// ===== common/its_pkg.sv
// Shared constants and types of the transfer status block.
// Assumes a 32-bit Avalon-MM register port and a link-side event bundle.
package its_pkg;

    // Register byte offsets
    localparam logic [4:0] OFS_BUS_CONTROL   = 5'h00;
    localparam logic [4:0] OFS_TX_FIFO_WRITE = 5'h10;
    localparam logic [4:0] OFS_STATUS        = 5'h14;

    // Field positions and reset values
    localparam int          SOFTWARE_BROADCAST_CALL_HANDLING_BIT    = 0;
    localparam logic        RST_SOFTWARE_BROADCAST_CALL_HANDLING    = 1'b0;
    localparam logic [7:0]  RST_TX_WORD = 8'h00;
    localparam logic [31:0] RST_RDATA   = 32'h0000_0000;

    // Link framing counts and broadcast address
    localparam logic [3:0] BITS_PER_BYTE      = 4'h9;
    localparam int         WTS_LEN_MAX_BYTES  = 2047;
    localparam logic [6:0] BROADCAST_ADDR     = 7'h00;

    typedef enum logic [1:0] {
        KIND_CONTROLLER_WRITE = 2'h0,
        KIND_CONTROLLER_READ  = 2'h1,
        KIND_WRITE_TO_TARGET  = 2'h2,
        KIND_READ_FROM_TARGET = 2'h3
    } its_kind_t;

    typedef enum logic [1:0] {
        PROG_IDLE = 2'h0,
        PROG_BUSY = 2'h1,
        PROG_OK   = 2'h2,
        PROG_ABORT = 2'h3
    } its_prog_t;

    typedef enum logic [2:0] {
        CAUSE_ADDRESS_REFUSED = 3'h0,
        CAUSE_DATA_REFUSED    = 3'h1,
        CAUSE_ARBITRATION_LOST        = 3'h3,
        CAUSE_EARLY_START     = 3'h4,
        CAUSE_EARLY_STOP      = 3'h5,
        CAUSE_RX_OVERFLOW     = 3'h6
    } its_cause_t;

    typedef enum logic [1:0] {
        FRAME_NORMAL       = 2'h0,
        FRAME_BROADCAST    = 2'h1,
        FRAME_HW_BROADCAST = 2'h2
    } its_frame_t;

    // Status word, bits 8:0 of transfer_status
    typedef struct packed {
        its_frame_t frame;
        its_cause_t cause;
        its_prog_t  prog;
        its_kind_t  kind;
    } its_status_t;

    // Events from the bus engine, all on the link clock
    typedef struct packed {
        logic       op_start;
        its_kind_t  op_kind;
        logic [6:0] op_addr;
        logic       addr_nack;
        logic       data_nack;
        logic       arbitration_lost;
        logic       bit_done;
        logic       start_seen;
        logic       stop_seen;
        logic       rx_byte;
        logic [7:0] rx_data;
    } its_link_ev_t;

endpackage : its_pkg

// ===== core/its_sync.sv
// Two-flop level synchroniser.
// Assumes the input is a level that holds for several destination clocks.
`timescale 1ns/1ns
module its_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             rst_b_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_reg;

    if (WIDTH < 1) begin : g_chk
        $error("its_sync: WIDTH must be at least 1");
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_reg <= '0;
            q_o      <= '0;
        end else begin
            meta_reg <= d_i;
            q_o      <= meta_reg;
        end
    end
endmodule : its_sync

// ===== core/its_word_cross.sv
// Toggle handshake that carries a word from one clock domain to another.
// Assumes both clocks run while a word is in flight.
`timescale 1ns/1ns
module its_word_cross #(
    parameter int WIDTH = 9
) (
    input  wire logic             src_clk_i,
    input  wire logic             dst_clk_i,
    input  wire logic             rst_b_i,
    input  wire logic [WIDTH-1:0] src_word_i,
    output logic      [WIDTH-1:0] dst_word_o
);
    logic [WIDTH-1:0] snap_reg;
    logic             req_reg;
    logic             ack_reg;
    logic             req_at_dst;
    logic             ack_at_src;
    wire  logic       src_free  = (req_reg == ack_at_src);
    wire  logic       src_load  = src_free && (src_word_i != snap_reg);
    wire  logic       dst_take  = (req_at_dst != ack_reg);

    if (WIDTH < 1) begin : g_chk
        $error("its_word_cross: WIDTH must be at least 1");
    end

    its_sync #(.WIDTH(1)) u_req_sync (
        .clk_i   (dst_clk_i),
        .rst_b_i (rst_b_i),
        .d_i     (req_reg),
        .q_o     (req_at_dst)
    );

    its_sync #(.WIDTH(1)) u_ack_sync (
        .clk_i   (src_clk_i),
        .rst_b_i (rst_b_i),
        .d_i     (ack_reg),
        .q_o     (ack_at_src)
    );

    // Snapshot holds still until the far side has taken it
    always_ff @(posedge src_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            snap_reg <= '0;
            req_reg  <= 1'b0;
        end else if (src_load) begin
            snap_reg <= src_word_i;
            req_reg  <= ~req_reg;
        end
    end

    always_ff @(posedge dst_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dst_word_o <= '0;
            ack_reg    <= 1'b0;
        end else if (dst_take) begin
            dst_word_o <= snap_reg;
            ack_reg    <= req_at_dst;
        end
    end
endmodule : its_word_cross

// ===== core/its_top.sv
// Transfer status reporting for a two-wire bus controller/target.
// Assumes bus engine events arrive on link_clk_i; registers on ref_clk_i.
`timescale 1ns/1ns
// Overview of operation
// - Report transfer kind in bits 1:0
// - Report idle, busy, done, aborted in 3:2
// - Abort reason only valid when aborted
// - Address not acknowledged aborts with 000b
// - Write data not acknowledged aborts 001b
// - Lost arbitration aborts with 011b
// - Start inside a byte aborts 100b
// - Stop inside a byte aborts 101b
// - Target write past 2047 bytes refused, 110b
// - Target write frame kind, normal is 00b
// - Broadcast call to target reports 01b
// - Software-bit broadcast: store control word only
// - Hardware broadcast call reports 10b
module its_top
    import its_pkg::*;
#(
    parameter int LEN_WIDTH = 11
) (
    input  wire logic         ref_clk_i,
    input  wire logic         rst_b_i,
    input  wire logic         link_clk_i,
    input  wire logic [4:0]   avs_address_i,
    input  wire logic         avs_read_i,
    input  wire logic         avs_write_i,
    input  wire logic [3:0]   avs_byteenable_i,
    input  wire logic [31:0]  avs_writedata_i,
    output logic      [31:0]  avs_readdata_o,
    output logic              avs_waitrequest_o,
    output logic      [7:0]   tx_word_o,
    output logic              tx_push_o,
    input  wire its_link_ev_t link_ev_i,
    output logic              refuse_ack_o,
    output logic              rx_store_o,
    output logic      [7:0]   rx_store_data_o
);

    if (((1 << LEN_WIDTH) - 1) != WTS_LEN_MAX_BYTES) begin : g_chk
        $error("its_top: LEN_WIDTH must count exactly to 2047");
    end

    // ---------------- Register side (ref_clk_i) ----------------
    logic        wait_reg;
    logic        software_broadcast_call_handling_reg;
    logic [7:0]  txw_reg;
    logic        push_reg;
    its_status_t status_ref;

    wire logic sel_ctrl   = (avs_address_i == OFS_BUS_CONTROL);
    wire logic sel_txw    = (avs_address_i == OFS_TX_FIFO_WRITE);
    wire logic sel_status = (avs_address_i == OFS_STATUS);
    wire logic take_req   = (avs_read_i || avs_write_i) && wait_reg;
    wire logic wr_fire    = avs_write_i && !wait_reg;
    wire logic wr_ctrl    = wr_fire && sel_ctrl && avs_byteenable_i[0];
    wire logic wr_txw     = wr_fire && sel_txw && avs_byteenable_i[0];

    wire logic [31:0] rd_word =
        sel_status ? {23'h0, status_ref} :
        sel_ctrl   ? {31'h0, software_broadcast_call_handling_reg} :
        sel_txw    ? {24'h0, txw_reg} :
                     32'h0;

    // One wait cycle, then a single cycle with waitrequest low
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wait_reg       <= 1'b1;
            avs_readdata_o <= RST_RDATA;
        end else begin
            wait_reg <= !take_req;
            if (take_req) begin
                avs_readdata_o <= rd_word;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            software_broadcast_call_handling_reg <= RST_SOFTWARE_BROADCAST_CALL_HANDLING;
            txw_reg  <= RST_TX_WORD;
            push_reg <= 1'b0;
        end else begin
            push_reg <= wr_txw;
            if (wr_ctrl) begin
                software_broadcast_call_handling_reg <= avs_writedata_i[SOFTWARE_BROADCAST_CALL_HANDLING_BIT];
            end
            if (wr_txw) begin
                txw_reg <= avs_writedata_i[7:0];
            end
        end
    end

    assign avs_waitrequest_o = wait_reg;
    assign tx_word_o         = txw_reg;
    assign tx_push_o         = push_reg;

    // ---------------- Link side (link_clk_i) ----------------
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_BUSY  = 4'b0010,
        ST_OK    = 4'b0100,
        ST_ABORT = 4'b1000
    } its_state_t;

    its_state_t           state_reg, state_next;
    its_kind_t            kind_reg, kind_next;
    its_cause_t           cause_reg, cause_next;
    its_frame_t           frame_reg, frame_next;
    logic [3:0]           bit_reg, bit_next;
    logic [LEN_WIDTH-1:0] len_reg, len_next;
    logic                 bcast_reg, bcast_next;
    logic                 ctl_wait_reg, ctl_wait_next;
    logic                 refuse_reg, refuse_next;
    logic                 store_next;
    logic [7:0]           sdata_next;
    logic                 software_broadcast_call_handling_link;
    its_status_t          status_live;
    its_prog_t            prog_live;

    its_sync #(.WIDTH(1)) u_software_broadcast_call_handling_sync (
        .clk_i   (link_clk_i),
        .rst_b_i (rst_b_i),
        .d_i     (software_broadcast_call_handling_reg),
        .q_o     (software_broadcast_call_handling_link)
    );

    wire logic busy      = (state_reg == ST_BUSY);
    wire logic mid_byte  = (bit_reg != 4'h0);
    wire logic err_start = busy && mid_byte && link_ev_i.start_seen;
    wire logic err_stop  = busy && mid_byte && link_ev_i.stop_seen && !link_ev_i.start_seen;
    wire logic go        = link_ev_i.op_start && !err_start && !err_stop;
    wire logic edge_ev   = link_ev_i.start_seen || link_ev_i.stop_seen || link_ev_i.op_start;
    wire logic quiet     = busy && !edge_ev;
    wire logic is_ctrl   = (kind_reg == KIND_CONTROLLER_WRITE) ||
                           (kind_reg == KIND_CONTROLLER_READ);
    wire logic is_wts    = (kind_reg == KIND_WRITE_TO_TARGET);
    wire logic ev_arb    = quiet && is_ctrl && link_ev_i.arbitration_lost;
    wire logic ev_anack  = quiet && is_ctrl && !link_ev_i.arbitration_lost && link_ev_i.addr_nack;
    wire logic ev_dnack  = quiet && (kind_reg == KIND_CONTROLLER_WRITE) &&
                           !link_ev_i.arbitration_lost && !link_ev_i.addr_nack &&
                           link_ev_i.data_nack;
    wire logic ev_rx     = quiet && is_wts && link_ev_i.rx_byte;
    wire logic hw_gc     = bcast_reg && software_broadcast_call_handling_link;
    wire logic len_full  = (len_reg == LEN_WIDTH'(WTS_LEN_MAX_BYTES));
    wire logic new_bcast = (link_ev_i.op_kind == KIND_WRITE_TO_TARGET) &&
                           (link_ev_i.op_addr == BROADCAST_ADDR);

    always_comb begin
        state_next    = state_reg;
        kind_next     = kind_reg;
        cause_next    = cause_reg;
        frame_next    = frame_reg;
        bit_next      = bit_reg;
        len_next      = len_reg;
        bcast_next    = bcast_reg;
        ctl_wait_next = ctl_wait_reg;
        refuse_next   = refuse_reg && !(link_ev_i.start_seen || link_ev_i.stop_seen);
        store_next    = 1'b0;
        sdata_next    = rx_store_data_o;
        if (link_ev_i.bit_done) begin
            bit_next = (bit_reg == BITS_PER_BYTE - 4'h1) ? 4'h0 : bit_reg + 4'h1;
        end
        if (err_start) begin
            state_next = ST_ABORT;
            cause_next = CAUSE_EARLY_START;
            bit_next   = 4'h0;
        end else if (err_stop) begin
            state_next = ST_ABORT;
            cause_next = CAUSE_EARLY_STOP;
            bit_next   = 4'h0;
        end else if (link_ev_i.op_start) begin
            state_next    = ST_BUSY;
            kind_next     = link_ev_i.op_kind;
            cause_next    = CAUSE_ADDRESS_REFUSED;
            frame_next    = new_bcast ? FRAME_BROADCAST : FRAME_NORMAL;
            bcast_next    = new_bcast;
            ctl_wait_next = new_bcast;
            len_next      = '0;
            bit_next      = 4'h0;
            refuse_next   = 1'b0;
        end else if (busy && edge_ev) begin
            state_next = ST_OK;
            bit_next   = 4'h0;
        end else if (ev_arb) begin
            state_next = ST_ABORT;
            cause_next = CAUSE_ARBITRATION_LOST;
        end else if (ev_anack) begin
            state_next = ST_ABORT;
            cause_next = CAUSE_ADDRESS_REFUSED;
        end else if (ev_dnack) begin
            state_next = ST_ABORT;
            cause_next = CAUSE_DATA_REFUSED;
        end else if (ev_rx) begin
            if (ctl_wait_reg) begin
                ctl_wait_next = 1'b0;
                if (link_ev_i.rx_data[0]) begin
                    frame_next = FRAME_HW_BROADCAST;
                end
            end
            if (ctl_wait_reg && hw_gc) begin
                store_next = 1'b1;
                sdata_next = link_ev_i.rx_data;
            end else if (hw_gc) begin
                store_next = 1'b0;
            end else if (len_full) begin
                state_next  = ST_ABORT;
                cause_next  = CAUSE_RX_OVERFLOW;
                refuse_next = 1'b1;
            end else begin
                len_next   = len_reg + LEN_WIDTH'(1);
                store_next = 1'b1;
                sdata_next = link_ev_i.rx_data;
            end
        end
    end

    always_ff @(posedge link_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_reg       <= ST_IDLE;
            kind_reg        <= KIND_CONTROLLER_WRITE;
            cause_reg       <= CAUSE_ADDRESS_REFUSED;
            frame_reg       <= FRAME_NORMAL;
            bit_reg         <= 4'h0;
            len_reg         <= '0;
            bcast_reg       <= 1'b0;
            ctl_wait_reg    <= 1'b0;
            refuse_reg      <= 1'b0;
            rx_store_o      <= 1'b0;
            rx_store_data_o <= 8'h00;
        end else begin
            state_reg       <= state_next;
            kind_reg        <= kind_next;
            cause_reg       <= cause_next;
            frame_reg       <= frame_next;
            bit_reg         <= bit_next;
            len_reg         <= len_next;
            bcast_reg       <= bcast_next;
            ctl_wait_reg    <= ctl_wait_next;
            refuse_reg      <= refuse_next;
            rx_store_o      <= store_next;
            rx_store_data_o <= sdata_next;
        end
    end

    assign refuse_ack_o = refuse_reg;

    always_comb begin
        unique case (state_reg)
            ST_IDLE:  prog_live = PROG_IDLE;
            ST_BUSY:  prog_live = PROG_BUSY;
            ST_OK:    prog_live = PROG_OK;
            ST_ABORT: prog_live = PROG_ABORT;
            default:  prog_live = PROG_IDLE;
        endcase
    end

    // Cause reads zero unless aborted; frame kind only for target writes
    assign status_live.kind  = kind_reg;
    assign status_live.prog  = prog_live;
    assign status_live.cause = (state_reg == ST_ABORT) ? cause_reg
                                                       : CAUSE_ADDRESS_REFUSED;
    assign status_live.frame = is_wts ? frame_reg : FRAME_NORMAL;

    its_word_cross #(.WIDTH($bits(its_status_t))) u_status_cross (
        .src_clk_i  (link_clk_i),
        .dst_clk_i  (ref_clk_i),
        .rst_b_i    (rst_b_i),
        .src_word_i (status_live),
        .dst_word_o (status_ref)
    );

    // ---------------- Checks (link_clk_i) ----------------
    AST_KIND_LATCH: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
        go |=> status_live.kind == $past(link_ev_i.op_kind))
        else $error("transfer kind not taken at start");

    AST_PROG_BUSY: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
        go |=> status_live.prog == PROG_BUSY ##0 busy)
        else $error("progress not busy after start");

    AST_CAUSE_VALID: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
        (status_live.cause != 3'h2) && (status_live.cause != 3'h7) &&
        ((status_live.prog == PROG_ABORT) || (status_live.cause == 3'h0)))
        else $error("abort reason shown while not aborted");

    AST_ADDR_REFUSED: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
        ev_anack |=> status_live.prog == PROG_ABORT && status_live.cause == 3'h0)
        else $error("address refusal not reported");

    AST_DATA_REFUSED: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
        ev_dnack |=> status_live.prog == PROG_ABORT && status_live.cause == 3'h1)
        else $error("data refusal not reported");

    AST_ARBITRATION_LOST: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
        ev_arb |=> status_live.prog == PROG_ABORT && status_live.cause == 3'h3)
        else $error("arbitration loss not reported");

    AST_EARLY_START: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
        err_start |=> status_live.prog == PROG_ABORT && status_live.cause == 3'h4)
        else $error("start inside a byte not reported");

    AST_EARLY_STOP: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
        err_stop |=> status_live.prog == PROG_ABORT && status_live.cause == 3'h5)
        else $error("stop inside a byte not reported");

    AST_OVERFLOW: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
        (ev_rx && !hw_gc && len_full) |=> refuse_ack_o && !rx_store_o &&
        status_live.cause == 3'h6)
        else $error("overflow byte not refused");

    AST_FRAME_NORMAL: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
        (go && link_ev_i.op_kind == KIND_WRITE_TO_TARGET && !new_bcast)
        |=> status_live.frame == 2'h0)
        else $error("normal frame kind wrong");

    AST_BROADCAST: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
        (go && new_bcast) |=> status_live.frame == 2'h1 && status_live.kind == 2'h2)
        else $error("broadcast call not reported");

    AST_HW_GC_ONLY: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
        (ev_rx && hw_gc && !ctl_wait_reg) |=> !rx_store_o && len_reg == '0)
        else $error("data stored after handled broadcast");

    AST_HW_GC_TYPE: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
        (ev_rx && ctl_wait_reg && link_ev_i.rx_data[0]) |=> status_live.frame == 2'h2)
        else $error("hardware broadcast kind not reported");

endmodule : its_top

// ===== tb/its_link_model.sv
// Far-side model: other two-wire bus parties, seen as the bus engine's event stream.
// Assumes the bench calls send() from one process at a time.
`timescale 1ns/1ns
module its_link_model
    import its_pkg::*;
(
    input  wire logic   link_clk_i,
    output its_link_ev_t ev_o
);
    initial ev_o = '0;

    // One-cycle event after an optional idle gap; released data lines show inverted garbage
    task automatic send(input its_link_ev_t e, input int gap);
        its_link_ev_t idle;
        idle         = '0;
        idle.op_kind = its_kind_t'(~e.op_kind);
        idle.op_addr = ~e.op_addr;
        idle.rx_data = ~e.rx_data;
        repeat (gap) @(posedge link_clk_i);
        @(posedge link_clk_i);
        ev_o <= e;
        @(posedge link_clk_i);
        ev_o <= idle;
    endtask : send
endmodule : its_link_model

// ===== tb/testbench.sv
// Self-checking bench of the transfer status block.
// Assumes its_top and the link model; reads go through a queue of expected words.
`timescale 1ns/1ns
module testbench
    import its_pkg::*;
;
    logic ref_clk_i, link_clk_i, rst_b_i, rd, wr;
    logic [4:0] adr;
    logic [31:0] wdat, rdat, d;
    logic wait_b, push, refuse, store;
    logic [3:0] be;
    logic [7:0] txw, rxd;
    its_link_ev_t ev;
    int fail_count, num_checks;
    logic [31:0] rq[$];
    logic [7:0] tq[$], xq[$];
    its_kind_t kk[5] = '{KIND_CONTROLLER_READ, KIND_CONTROLLER_WRITE, KIND_CONTROLLER_READ,
                         KIND_CONTROLLER_WRITE, KIND_CONTROLLER_READ};
    its_cause_t cc[5] = '{CAUSE_ADDRESS_REFUSED, CAUSE_DATA_REFUSED, CAUSE_ARBITRATION_LOST,
                          CAUSE_EARLY_START, CAUSE_EARLY_STOP};

    its_top u_dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .link_clk_i(link_clk_i),
        .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_byteenable_i(be),
        .avs_writedata_i(wdat), .avs_readdata_o(rdat), .avs_waitrequest_o(wait_b),
        .tx_word_o(txw), .tx_push_o(push), .link_ev_i(ev), .refuse_ack_o(refuse),
        .rx_store_o(store), .rx_store_data_o(rxd));
    its_link_model u_link (.link_clk_i(link_clk_i), .ev_o(ev));

    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        link_clk_i = 1'b0;
        #3;
        forever #40 link_clk_i = ~link_clk_i;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic finish_test;
        if (fail_count == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : finish_test

    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] dd);
        int n;
        n = 0;
        @(posedge ref_clk_i);
        adr  <= a;
        wdat <= dd;
        wr   <= w;
        rd   <= !w;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (wait_b !== 1'b0 && n < 50);
        rd <= 1'b0;
        wr <= 1'b0;
        if (n >= 50) begin
            fail_count++;
            finish_test();
        end
    endtask : bus

    task automatic rdx(input logic [4:0] a, input logic [31:0] e);
        rq.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask : rdx

    function automatic logic [31:0] st(input logic [1:0] k, input logic [1:0] p,
                                       input logic [2:0] c, input logic [1:0] f);
        return {23'h0, f, c, p, k};
    endfunction : st

    task automatic op(input its_kind_t k, input logic [6:0] a);
        its_link_ev_t e;
        e = '0;
        e.op_start = 1'b1;
        e.op_kind  = k;
        e.op_addr  = a;
        u_link.send(e, $urandom_range(2));
    endtask : op

    // 0 addr nack, 1 data nack, 2 arbitration_lost, 3 start, 4 stop, 5 bit done
    task automatic evt(input int s);
        its_link_ev_t e;
        e = '0;
        case (s)
            0: e.addr_nack = 1'b1;
            1: e.data_nack = 1'b1;
            2: e.arbitration_lost = 1'b1;
            3: e.start_seen = 1'b1;
            4: e.stop_seen = 1'b1;
            default: e.bit_done = 1'b1;
        endcase
        u_link.send(e, 0);
    endtask : evt

    task automatic rxb(input logic [7:0] v, input logic kept);
        its_link_ev_t e;
        e = '0;
        e.rx_byte = 1'b1;
        e.rx_data = v;
        if (kept)
            xq.push_back(v);
        u_link.send(e, 0);
    endtask : rxb

    task automatic settle;
        repeat (12) @(posedge link_clk_i);
    endtask : settle

    always @(posedge ref_clk_i) begin
        if (rd && wait_b === 1'b0)
            chk(rdat, rq.pop_front());
        if (push === 1'b1)
            chk({24'h0, txw}, {24'h0, tq.pop_front()});
    end
    always @(posedge link_clk_i) begin
        if (store === 1'b1)
            chk({24'h0, rxd}, {24'h0, xq.pop_front()});
    end

    initial begin
        #600_000;
        fail_count++;
        finish_test();
    end

    initial begin
        {rst_b_i, rd, wr, adr, wdat, fail_count, num_checks} = '0;
        be = 4'hf;
        repeat (20) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        void'($urandom(32'h0cb8));
        rdx(OFS_STATUS, 32'h0);
        rdx(5'h08, 32'h0);
        bus(1'b1, OFS_STATUS, 32'hffff_ffff);
        rdx(OFS_STATUS, 32'h0);
        d = $urandom;
        tq.push_back(d[7:0]);
        bus(1'b1, OFS_TX_FIFO_WRITE, d);
        rdx(OFS_TX_FIFO_WRITE, {24'h0, d[7:0]});
        for (int k = 0; k < 4; k++) begin
            op(its_kind_t'(k), 7'h5a);
            settle();
            rdx(OFS_STATUS, st(2'(k), PROG_BUSY, 3'h0, FRAME_NORMAL));
            evt(4);
            settle();
            rdx(OFS_STATUS, st(2'(k), PROG_OK, 3'h0, FRAME_NORMAL));
        end
        for (int i = 0; i < 5; i++) begin
            op(kk[i], 7'h21);
            if (i >= 3)
                evt(5);
            evt(i);
            settle();
            rdx(OFS_STATUS, st(kk[i], PROG_ABORT, cc[i], 2'h0));
        end
        op(KIND_WRITE_TO_TARGET, 7'h33);
        evt(0);
        rxb(8'($urandom), 1'b1);
        settle();
        rdx(OFS_STATUS, st(2'h2, PROG_BUSY, 3'h0, FRAME_NORMAL));
        evt(4);
        bus(1'b1, OFS_BUS_CONTROL, 32'h0);
        be <= 4'h0;
        bus(1'b1, OFS_BUS_CONTROL, 32'h1);
        be <= 4'hf;
        rdx(OFS_BUS_CONTROL, 32'h0);
        op(KIND_WRITE_TO_TARGET, BROADCAST_ADDR);
        rxb(8'h06, 1'b1);
        rxb(8'h91, 1'b1);
        settle();
        rdx(OFS_STATUS, st(2'h2, PROG_BUSY, 3'h0, FRAME_BROADCAST));
        evt(4);
        bus(1'b1, OFS_BUS_CONTROL, 32'h1);
        rdx(OFS_BUS_CONTROL, 32'h1);
        op(KIND_WRITE_TO_TARGET, BROADCAST_ADDR);
        rxb(8'h07, 1'b1);
        rxb(8'h55, 1'b0);
        settle();
        rdx(OFS_STATUS, st(2'h2, PROG_BUSY, 3'h0, FRAME_HW_BROADCAST));
        evt(4);
        bus(1'b1, OFS_BUS_CONTROL, 32'h0);
        op(KIND_WRITE_TO_TARGET, 7'h44);
        repeat (WTS_LEN_MAX_BYTES) rxb(8'($urandom), 1'b1);
        rxb(8'($urandom), 1'b0);
        settle();
        rdx(OFS_STATUS, st(2'h2, PROG_ABORT, CAUSE_RX_OVERFLOW, 2'h0));
        chk({31'h0, refuse}, 32'h1);
        evt(3);
        settle();
        chk({31'h0, refuse}, 32'h0);
        chk(rq.size() + tq.size() + xq.size(), 32'h0);
        finish_test();
    end
endmodule : testbench
